// ### core/fld_pkg.sv
package fld_pkg;

  // Flag bit positions in the event vector
  localparam int unsigned FLG_RAW  = 0;
  localparam int unsigned FLG_RING = 1;
  localparam int unsigned FLG_CAR  = 2;
  localparam int unsigned FLG_PKT  = 3;
  localparam int unsigned NUM_FLG  = 4;

  // Character framing
  localparam int unsigned CHAR_BITS = 10;
  localparam int unsigned DATA_BITS = 8;
  localparam logic [3:0]  BIT_LAST  = 4'h9;
  localparam logic [3:0]  BIT_ZERO  = 4'h0;

  // Bit timing: 1200 baud line, sampled mid-bit at 50 MHz
  localparam int unsigned CLK_HZ      = 50000000;
  localparam int unsigned BAUD_HZ     = 1200;
  localparam int unsigned BIT_CYC     = CLK_HZ / BAUD_HZ;
  localparam int unsigned HALF_CYC    = BIT_CYC / 2;
  localparam int unsigned BCNT_W      = 16;

  // Peripheral interrupt vector address
  localparam logic [11:0] PERIPH_VECTOR = 12'h010;

  // Reset values
  localparam logic        PWDN_RST = 1'b1;
  localparam logic        MASK_RST = 1'b1;
  localparam logic [7:0]  DATA_RST = 8'h00;

  // Framer states
  typedef enum logic [1:0] {
    FR_IDLE  = 2'b00,
    FR_START = 2'b01,
    FR_BITS  = 2'b10
  } fld_fr_state_t;

  // Analog demodulator side
  typedef struct packed {
    logic carrier;   // Carrier present
    logic data_vld;  // FSK data being detected
    logic raw_bit;   // Demodulated bit
    logic seizure;   // Inside channel-seizure pattern
  } fld_demod_t;

  // Software flag clear strobes (one per flag, active high)
  typedef struct packed {
    logic pkt;
    logic car;
    logic ring;
    logic raw;
  } fld_clr_t;

endpackage

// ### core/fld_edge_flag.sv
`timescale 1ns/1ns
`default_nettype none
// Sticky event flag with falling edge detection
module fld_edge_flag (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Event and control
  input  wire logic level_i,
  input  wire logic run_i,
  input  wire logic clr_i,
  // Status
  output logic      flag_o,
  output logic      set_o
);

  logic level_q;
  logic flag_q;

  // Previous level, idles high like the sources it watches
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      level_q <= 1'b1;
    end else begin
      level_q <= level_i;
    end
  end

  assign set_o = run_i & level_q & ~level_i;

  // Set wins over clear; no other clear path
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flag_q <= 1'b0;
    end else if (set_o) begin
      flag_q <= 1'b1;
    end else if (clr_i) begin
      flag_q <= 1'b0;
    end
  end

  assign flag_o = flag_q;

endmodule
`default_nettype wire

// ### core/fld_decoder.sv
`timescale 1ns/1ns
`default_nettype none
// Digital side of the line FSK decoder with its four event flags
module fld_decoder #(
  // Line bit time in clock cycles
  parameter int unsigned BIT_CYC = fld_pkg::BIT_CYC
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               srst_i,
  // Analog front end
  input  wire fld_pkg::fld_demod_t demod_i,
  input  wire logic               ring_sense_input_i,
  input  wire logic               line_reversal_input_i,
  // Control bits
  input  wire logic               decoder_power_down_i,
  input  wire logic               packet_source_select_i,
  input  wire logic               raw_edge_irq_enable_i,
  input  wire logic               ring_irq_mask_i,
  input  wire logic               carrier_irq_mask_i,
  input  wire logic               packet_irq_mask_i,
  input  wire logic               peripheral_irq_enable_i,
  input  wire fld_pkg::fld_clr_t  flag_clr_i,
  input  wire logic               periph_flag_clr_i,
  // Status bits
  output logic                    raw_serial_bit_o,
  output logic                    cooked_serial_bit_o,
  output logic                    ring_envelope_signal_o,
  output logic                    raw_edge_flag_o,
  output logic                    ring_detect_flag_o,
  output logic                    carrier_detect_flag_o,
  output logic                    packet_ready_flag_o,
  output logic [7:0]              decoder_data_reg_o,
  output logic                    peripheral_request_flag_o,
  output logic                    irq_call_o,
  output logic [11:0]             irq_vector_o
);

  logic                     run;
  logic                     raw_d;
  logic                     cooked_d;
  logic                     raw_q;
  logic                     cooked_q;
  logic                     env_q;
  logic                     car_q;
  logic                     car_flag_q;
  logic                     car_set;
  logic                     raw_flag;
  logic                     raw_set;
  logic                     ring_flag;
  logic                     ring_set;
  logic                     pkt_flag_q;
  logic                     pkt_set;
  logic                     src_bit;
  fld_pkg::fld_fr_state_t   fr_q;
  logic [fld_pkg::BCNT_W-1:0] bcnt_q;
  logic [3:0]               bidx_q;
  logic [7:0]               shift_q;
  logic [7:0]               data_q;
  logic [fld_pkg::NUM_FLG-1:0] flags;
  logic [fld_pkg::NUM_FLG-1:0] sets;
  logic [fld_pkg::NUM_FLG-1:0] en;
  logic [fld_pkg::NUM_FLG-1:0] pend_q;
  logic                     req_q;
  logic                     call_q;

  // Start bit is confirmed half a bit time after its falling edge
  localparam int unsigned HALF_CYC = BIT_CYC / 2;

  // Decoding runs only while powered up
  assign run = ~decoder_power_down_i;

  // Serial streams: high when idle, cooked hides seizure
  assign raw_d    = (run & demod_i.data_vld) ? demod_i.raw_bit : 1'b1;
  assign cooked_d = (run & demod_i.data_vld & ~demod_i.seizure)
                  ? demod_i.raw_bit : 1'b1;

  // Registered serial bits
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      raw_q    <= 1'b1;
      cooked_q <= 1'b1;
    end else begin
      raw_q    <= raw_d;
      cooked_q <= cooked_d;
    end
  end

  // Envelope low while ring or reversal present, even in power-down
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      env_q <= 1'b1;
    end else begin
      env_q <= ~(ring_sense_input_i | line_reversal_input_i);
    end
  end

  // Raw stream falling edge flag
  fld_edge_flag u_raw_flag (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .level_i (raw_q),
    .run_i   (run),
    .clr_i   (flag_clr_i.raw),
    .flag_o  (raw_flag),
    .set_o   (raw_set)
  );

  // Ring envelope falling edge flag, not gated by power-down
  fld_edge_flag u_ring_flag (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .level_i (env_q),
    .run_i   (1'b1),
    .clr_i   (flag_clr_i.ring),
    .flag_o  (ring_flag),
    .set_o   (ring_set)
  );

  // Carrier rising edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      car_q <= 1'b0;
    end else begin
      car_q <= run & demod_i.carrier;
    end
  end

  assign car_set = run & demod_i.carrier & ~car_q;

  // Carrier flag: set wins over software clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      car_flag_q <= 1'b0;
    end else if (car_set) begin
      car_flag_q <= 1'b1;
    end else if (flag_clr_i.car) begin
      car_flag_q <= 1'b0;
    end
  end

  // Framer source: raw or cooked stream
  assign src_bit = packet_source_select_i ? cooked_q : raw_q;

  // Framer: start on zero, sample mid-bit, ten bits per character
  always_ff @(posedge clk_i) begin
    if (srst_i || !run) begin
      fr_q   <= fld_pkg::FR_IDLE;
      bcnt_q <= '0;
      bidx_q <= fld_pkg::BIT_ZERO;
    end else begin
      case (fr_q)
        fld_pkg::FR_IDLE: begin
          bcnt_q <= '0;
          bidx_q <= fld_pkg::BIT_ZERO;
          if (!src_bit) begin
            fr_q <= fld_pkg::FR_START;
          end
        end
        fld_pkg::FR_START: begin
          if (bcnt_q == fld_pkg::BCNT_W'(HALF_CYC - 1)) begin
            bcnt_q <= '0;
            if (src_bit) begin
              fr_q <= fld_pkg::FR_IDLE;  // Glitch, not a start bit
            end else begin
              fr_q   <= fld_pkg::FR_BITS;
              bidx_q <= 4'h1;
            end
          end else begin
            bcnt_q <= bcnt_q + 1'b1;
          end
        end
        fld_pkg::FR_BITS: begin
          if (bcnt_q == fld_pkg::BCNT_W'(BIT_CYC - 1)) begin
            bcnt_q <= '0;
            if (bidx_q == fld_pkg::BIT_LAST) begin
              fr_q <= fld_pkg::FR_IDLE;  // Tenth bit discarded
            end else begin
              bidx_q <= bidx_q + 1'b1;
            end
          end else begin
            bcnt_q <= bcnt_q + 1'b1;
          end
        end
        default: begin
          fr_q <= fld_pkg::FR_IDLE;
        end
      endcase
    end
  end

  // Shift in the middle eight bits, LSB first
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      shift_q <= fld_pkg::DATA_RST;
    end else if (fr_q == fld_pkg::FR_BITS && bidx_q != fld_pkg::BIT_LAST
                 && bcnt_q == fld_pkg::BCNT_W'(BIT_CYC - 1)) begin
      shift_q <= {src_bit, shift_q[7:1]};
    end
  end

  // Byte completes at the tenth bit sample
  assign pkt_set = run && fr_q == fld_pkg::FR_BITS
                && bidx_q == fld_pkg::BIT_LAST
                && bcnt_q == fld_pkg::BCNT_W'(BIT_CYC - 1);

  // Data register holds the last framed byte
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      data_q <= fld_pkg::DATA_RST;
    end else if (pkt_set) begin
      data_q <= shift_q;
    end
  end

  // Packet flag: set wins over clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pkt_flag_q <= 1'b0;
    end else if (pkt_set) begin
      pkt_flag_q <= 1'b1;
    end else if (flag_clr_i.pkt) begin
      pkt_flag_q <= 1'b0;
    end
  end

  assign flags = {pkt_flag_q, car_flag_q, ring_flag, raw_flag};
  assign sets  = {pkt_set, car_set, ring_set, raw_set};

  // Source enables; raw-edge enable overrides the masks
  assign en[fld_pkg::FLG_RAW]  = raw_edge_irq_enable_i;
  assign en[fld_pkg::FLG_RING] = ~raw_edge_irq_enable_i & ~ring_irq_mask_i;
  assign en[fld_pkg::FLG_CAR]  = ~raw_edge_irq_enable_i & ~carrier_irq_mask_i;
  assign en[fld_pkg::FLG_PKT]  = ~raw_edge_irq_enable_i & ~packet_irq_mask_i;

  // Per-source request only on a fresh set while flag clear
  genvar g;
  generate
    for (g = 0; g < fld_pkg::NUM_FLG; g++) begin : g_src
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          pend_q[g] <= 1'b0;
        end else begin
          pend_q[g] <= sets[g] & ~flags[g] & en[g];
        end
      end
    end
  endgenerate

  // Peripheral request flag and vector call pulse
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      req_q  <= 1'b0;
      call_q <= 1'b0;
    end else begin
      call_q <= peripheral_irq_enable_i & (|pend_q);
      if (peripheral_irq_enable_i && (|pend_q)) begin
        req_q <= 1'b1;
      end else if (periph_flag_clr_i) begin
        req_q <= 1'b0;
      end
    end
  end

  // Registered outputs and the constant vector address
  assign raw_serial_bit_o          = raw_q;
  assign cooked_serial_bit_o       = cooked_q;
  assign ring_envelope_signal_o    = env_q;
  assign raw_edge_flag_o           = raw_flag;
  assign ring_detect_flag_o        = ring_flag;
  assign carrier_detect_flag_o     = car_flag_q;
  assign packet_ready_flag_o       = pkt_flag_q;
  assign decoder_data_reg_o        = data_q;
  assign peripheral_request_flag_o = req_q;
  assign irq_call_o                = call_q;
  assign irq_vector_o              = fld_pkg::PERIPH_VECTOR;

endmodule
`default_nettype wire

// ### testbench/fld_decoder_chk.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level timing checks on the line decoder
module fld_decoder_chk (
  // Clock and reset
  input wire logic               clk_i,
  input wire logic               srst_i,
  // Inputs
  input wire fld_pkg::fld_demod_t demod_i,
  input wire logic               ring_sense_input_i,
  input wire logic               line_reversal_input_i,
  input wire logic               decoder_power_down_i,
  input wire logic               peripheral_irq_enable_i,
  input wire fld_pkg::fld_clr_t  flag_clr_i,
  // Outputs
  input wire logic               raw_serial_bit_o,
  input wire logic               cooked_serial_bit_o,
  input wire logic               ring_envelope_signal_o,
  input wire logic               ring_detect_flag_o,
  input wire logic               carrier_detect_flag_o,
  input wire logic               peripheral_request_flag_o,
  input wire logic               irq_call_o,
  input wire logic [11:0]        irq_vector_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_idle_high: assert property (
    !demod_i.data_vld |=> raw_serial_bit_o && cooked_serial_bit_o)
    else $error("serial bits not high while idle");
  a_raw_follow: assert property (
    demod_i.data_vld && !decoder_power_down_i
    |=> raw_serial_bit_o == $past(demod_i.raw_bit))
    else $error("raw serial bit does not follow line");
  a_cook_seize: assert property (
    demod_i.data_vld && demod_i.seizure |=> cooked_serial_bit_o)
    else $error("cooked bit shows seizure pattern");
  a_env_low: assert property (
    ring_sense_input_i || line_reversal_input_i |=> !ring_envelope_signal_o)
    else $error("envelope high during ring or reversal");
  a_ring_set: assert property (
    $rose(ring_sense_input_i) && ring_envelope_signal_o
    && !line_reversal_input_i |-> ##2 ring_detect_flag_o)
    else $error("ring flag not set on envelope fall");
  a_car_set: assert property (
    $rose(demod_i.carrier) && !decoder_power_down_i
    && !$past(decoder_power_down_i) |=> carrier_detect_flag_o)
    else $error("carrier flag not set");
  a_car_pwdn: assert property (
    $rose(carrier_detect_flag_o) |-> !$past(decoder_power_down_i))
    else $error("carrier flag set in power-down");
  a_car_sticky: assert property (
    $fell(carrier_detect_flag_o) |-> $past(flag_clr_i.car))
    else $error("carrier flag fell without clear");
  a_ring_sticky: assert property (
    $fell(ring_detect_flag_o) |-> $past(flag_clr_i.ring))
    else $error("ring flag fell without clear");
  a_req_gate: assert property (
    $rose(peripheral_request_flag_o) |-> $past(peripheral_irq_enable_i))
    else $error("request raised while disabled");
  a_call_pulse: assert property (
    irq_call_o |-> irq_vector_o == fld_pkg::PERIPH_VECTOR ##1 !irq_call_o)
    else $error("call pulse or vector wrong");
endmodule
bind fld_decoder fld_decoder_chk fld_decoder_chk_inst (.clk_i, .srst_i,
  .demod_i, .ring_sense_input_i, .line_reversal_input_i,
  .decoder_power_down_i, .peripheral_irq_enable_i, .flag_clr_i,
  .raw_serial_bit_o, .cooked_serial_bit_o, .ring_envelope_signal_o,
  .ring_detect_flag_o, .carrier_detect_flag_o, .peripheral_request_flag_o,
  .irq_call_o, .irq_vector_o);
`default_nettype wire

// ### testbench/fld_line_model.sv
`timescale 1ns/1ns
`default_nettype none
// Behavioural line: demodulator levels and ring detector pins
module fld_line_model (
  // Clock
  input  wire logic               clk_i,
  // Line side
  output var fld_pkg::fld_demod_t demod_o,
  output var logic                ring_o,
  output var logic                rev_o
);
  initial begin
    demod_o = '0;
    ring_o = 1'b0;
    rev_o = 1'b0;
  end
  // Released data line toggles so a stale level never passes
  always @(posedge clk_i) begin
    if (!demod_o.data_vld) demod_o.raw_bit <= ~demod_o.raw_bit;
  end
  // Carrier present or gone
  task automatic carrier(input logic on);
    @(posedge clk_i);
    #1 demod_o.carrier = on;
  endtask
  // One bit held exactly len cycles; returns just after an edge
  task automatic send(input logic v, input logic seiz, input int len);
    @(posedge clk_i);
    #1 demod_o.data_vld = 1'b1;
    demod_o.raw_bit = v;
    demod_o.seizure = seiz;
    repeat (len - 1) @(posedge clk_i);
    #1;
  endtask
  // End of data: line released
  task automatic release_data;
    @(posedge clk_i);
    #1 demod_o.data_vld = 1'b0;
    demod_o.seizure = 1'b0;
  endtask
  // Ring burst or line reversal for len cycles
  task automatic ring(input logic rev, input int len);
    @(posedge clk_i);
    #1 if (rev) rev_o = 1'b1;
    else ring_o = 1'b1;
    repeat (len) @(posedge clk_i);
    #1 ring_o = 1'b0;
    rev_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### testbench/fld_decoder_tb.sv
`timescale 1ns/1ns
`default_nettype none
// Scenario bench for the line decoder
module fld_decoder_tb;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  fld_pkg::fld_demod_t demod;
  fld_pkg::fld_clr_t clr = '0;
  logic ring, rev, raw_b, cook_b, env, f_raw, f_ring, f_car, f_pkt, req, call;
  logic pwdn = 1'b1, sel = 1'b0, raw_en = 1'b0, carrier_irq_mask = 1'b1, pclr = 1'b0;
  logic ring_irq_mask = 1'b1, pmsk = 1'b1, pen = 1'b1;
  // Short bit time keeps a framed character within the run budget
  localparam int unsigned TB_BIT_CYC = 16;
  logic [7:0] data;
  logic [11:0] vec;
  int error_cnt = 0;
  int n_compared = 0;
  int i;
  always #10 clk_i = ~clk_i;
  fld_line_model fld_line_model_inst (.clk_i(clk_i), .demod_o(demod),
    .ring_o(ring), .rev_o(rev));
  fld_decoder #(.BIT_CYC(TB_BIT_CYC)) fld_decoder_inst (.clk_i(clk_i),
    .srst_i(srst_i), .demod_i(demod), .ring_sense_input_i(ring),
    .line_reversal_input_i(rev), .decoder_power_down_i(pwdn),
    .packet_source_select_i(sel), .raw_edge_irq_enable_i(raw_en),
    .ring_irq_mask_i(ring_irq_mask), .carrier_irq_mask_i(carrier_irq_mask),
    .packet_irq_mask_i(pmsk), .peripheral_irq_enable_i(pen),
    .flag_clr_i(clr), .periph_flag_clr_i(pclr),
    .raw_serial_bit_o(raw_b), .cooked_serial_bit_o(cook_b),
    .ring_envelope_signal_o(env), .raw_edge_flag_o(f_raw),
    .ring_detect_flag_o(f_ring), .carrier_detect_flag_o(f_car),
    .packet_ready_flag_o(f_pkt), .decoder_data_reg_o(data),
    .peripheral_request_flag_o(req), .irq_call_o(call),
    .irq_vector_o(vec));
  task automatic chk(input string nm, input logic [11:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // One-cycle software clear pulses
  task automatic clear(input logic [3:0] m, input logic p);
    clr = fld_pkg::fld_clr_t'(m);
    pclr = p;
    step(1);
    clr = '0;
    pclr = 1'b0;
  endtask
  // Start bit, eight data bits LSB first, short stop bit left standing
  task automatic put_char(input logic [7:0] b, input logic seiz);
    int k;
    fld_line_model_inst.send(1'b0, seiz, TB_BIT_CYC);
    for (k = 0; k < 8; k++) begin
      fld_line_model_inst.send(b[k], seiz, TB_BIT_CYC);
    end
    fld_line_model_inst.send(1'b1, seiz, 4);
  endtask
  // Request level and number of calls over a short window
  task automatic req_chk(input string nm, input logic [11:0] exp);
    int n;
    n = 0;
    repeat (8) begin
      step(1);
      if (call === 1'b1) n++;
    end
    chk(nm, exp, req);
    chk("call count", exp, 12'(n));
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    step(4);
    srst_i = 1'b0;
    step(2);
    chk("serial", 12'h003, {10'h000, raw_b, cook_b});
    chk("flags", 12'h000, {6'h00, f_raw, f_ring, f_car, f_pkt, req, call});
    chk("data", 12'h000, {4'h0, data});
    chk("envelope", 12'h001, {11'h000, env});
    fld_line_model_inst.carrier(1'b1);
    step(4);
    chk("carrier in power-down", 12'h000, {11'h000, f_car});
    fld_line_model_inst.ring(1'b0, 20);
    chk("ring in power-down", 12'h001, {11'h000, f_ring});
    req_chk("ring masked", 12'h000);
    clear(4'h2, 1'b0);
    chk("ring cleared", 12'h000, {11'h000, f_ring});
    fld_line_model_inst.carrier(1'b0);
    pwdn = 1'b0;
    fld_line_model_inst.carrier(1'b1);
    step(3);
    chk("carrier flag", 12'h001, {11'h000, f_car});
    req_chk("carrier masked", 12'h000);
    clear(4'h4, 1'b0);
    fld_line_model_inst.carrier(1'b0);
    carrier_irq_mask = 1'b0;
    fld_line_model_inst.carrier(1'b1);
    req_chk("carrier request", 12'h001);
    chk("vector", 12'h010, vec);
    clear(4'h0, 1'b1);
    chk("request cleared", 12'h000, {11'h000, req});
    fld_line_model_inst.carrier(1'b0);
    fld_line_model_inst.carrier(1'b1);
    req_chk("flag still set", 12'h000);
    chk("carrier sticky", 12'h001, {11'h000, f_car});
    clear(4'h4, 1'b0);
    fld_line_model_inst.carrier(1'b0);
    raw_en = 1'b1;
    fld_line_model_inst.carrier(1'b1);
    req_chk("raw enable override", 12'h000);
    fld_line_model_inst.send(1'b1, 1'b0, 4);
    fld_line_model_inst.send(1'b0, 1'b0, 2);
    fld_line_model_inst.send(1'b1, 1'b0, 1);
    req_chk("raw edge request", 12'h001);
    chk("raw flag", 12'h001, {11'h000, f_raw});
    clear(4'h1, 1'b1);
    sel = 1'b1;
    for (i = 0; i < 8; i++) begin
      fld_line_model_inst.send(i[0], 1'b1, 2);
      chk("raw seizure", {11'h000, i[0]}, {11'h000, raw_b});
      chk("cooked seizure", 12'h001, {11'h000, cook_b});
    end
    fld_line_model_inst.send(1'b1, 1'b0, 3000);
    chk("mark framed", 12'h000, {11'h000, f_pkt});
    raw_en = 1'b0;
    pmsk = 1'b0;
    clear(4'h1, 1'b1);
    put_char(8'hA5, 1'b0);
    req_chk("packet request", 12'h001);
    chk("packet flag", 12'h001, {11'h000, f_pkt});
    chk("packet data", 12'h0A5, {4'h0, data});
    clear(4'h8, 1'b1);
    sel = 1'b0;
    put_char(8'h3C, 1'b1);
    req_chk("raw source request", 12'h001);
    chk("raw source data", 12'h03C, {4'h0, data});
    ring_irq_mask = 1'b0;
    clear(4'h8, 1'b1);
    fld_line_model_inst.ring(1'b1, 2);
    req_chk("reversal request", 12'h001);
    chk("reversal flag", 12'h001, {11'h000, f_ring});
    clear(4'h2, 1'b1);
    pen = 1'b0;
    fld_line_model_inst.ring(1'b0, 2);
    req_chk("peripheral disabled", 12'h000);
    chk("ring flag", 12'h001, {11'h000, f_ring});
    fld_line_model_inst.release_data();
    step(3);
    chk("serial released", 12'h003, {10'h000, raw_b, cook_b});
    end_of_test();
  end
  // Watchdog well past the expected run length
  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
